// file: pkg/isr_pkg.sv
// Shared constants and types for the instrument status-reporting block
`default_nettype none

package isr_pkg;

    // ****************************************************************
    // Standard event flag bit positions
    // ****************************************************************
    localparam int SEF_OPERATION_COMPLETE = 0;
    localparam int SEF_CONTROL_REQUEST    = 1;
    localparam int SEF_QUERY_FAULT        = 2;
    localparam int SEF_DEVICE_FAULT       = 3;
    localparam int SEF_RUN_FAILURE        = 4;
    localparam int SEF_PARSE_ERROR        = 5;
    localparam int SEF_USER_REQUEST       = 6;
    localparam int SEF_POWER_UP           = 7;

    // ****************************************************************
    // Status summary byte bit positions
    // ****************************************************************
    localparam int SSB_COMPLETION_SUMMARY = 2;
    localparam int SSB_ERROR_SUMMARY      = 3;
    localparam int SSB_MESSAGE_READY      = 4;
    localparam int SSB_EVENT_SUMMARY      = 5;
    localparam int SSB_MASTER_SUMMARY     = 6;

    // ****************************************************************
    // Widths, masks and reset values
    // ****************************************************************
    localparam int         REG_WIDTH        = 8;
    localparam logic [7:0] SEF_USED_MASK    = 8'hbd;
    localparam logic [7:0] SEF_SERIAL_MASK  = 8'hb9;
    localparam logic [7:0] SEF_RESET_VALUE  = 8'h80;
    localparam logic [7:0] SEM_RESET_VALUE  = 8'h00;
    localparam logic [7:0] SRM_USED_MASK    = 8'h3c;
    localparam logic [7:0] SRM_RESET_VALUE  = 8'h00;
    localparam logic [7:0] SSB_USED_MASK    = 8'h7c;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;
    localparam logic [7:0] ASCII_ZERO       = 8'h30;
    localparam logic [7:0] DEC_HUNDRED      = 8'h64;
    localparam logic [7:0] DEC_TEN          = 8'h0a;

    // ****************************************************************
    // Common commands and queries handed over by the message parser
    // ****************************************************************
    typedef enum logic [3:0] {
        ISR_CMD_NONE      = 4'h0,
        ISR_CMD_CLEAR     = 4'h1,
        ISR_CMD_EVT_QUERY = 4'h2,
        ISR_CMD_EVM_WRITE = 4'h3,
        ISR_CMD_EVM_QUERY = 4'h4,
        ISR_CMD_SRM_WRITE = 4'h5,
        ISR_CMD_SRM_QUERY = 4'h6,
        ISR_CMD_STB_QUERY = 4'h7,
        ISR_CMD_OP_DONE   = 4'h8,
        ISR_CMD_SER_POLL  = 4'h9
    } isr_cmd_t;

    typedef enum logic [0:0] {
        ISR_OPC_IDLE = 1'b0,
        ISR_OPC_WAIT = 1'b1
    } isr_opc_t;

endpackage

`default_nettype wire

// file: hw/isr_flag_latch.sv
// Sticky event flag register with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none

module isr_flag_latch #(
    parameter int                WIDTH      = 8,
    parameter logic [WIDTH-1:0]  RESET_VAL  = '0,
    parameter logic [WIDTH-1:0]  USED_MASK  = '1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             clear_all,
    output var  logic [WIDTH-1:0] flags_reg
);
    import isr_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } isr_latch_state_t;

    isr_latch_state_t state_reg;
    isr_latch_state_t state_next;

    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("isr_flag_latch: WIDTH out of range");
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // An event in the clearing cycle survives so no event is lost.
    always_comb begin
        state_next = state_reg;
        if (clear_all) begin
            state_next.flags = '0;
        end
        state_next.flags = (state_next.flags | set_vec) & USED_MASK;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg.flags <= RESET_VAL & USED_MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags_reg = state_reg.flags;

endmodule

`default_nettype wire

// file: hw/isr_dec_text.sv
// Converts a byte into three ASCII decimal digits and a digit count
`timescale 1ns/1ps
`default_nettype none

module isr_dec_text (
    input  wire logic [7:0]  value,
    output var  logic [23:0] text,
    output var  logic [1:0]  digits
);
    import isr_pkg::*;

    function automatic logic [7:0] to_ascii(input logic [7:0] d);
        return d + ASCII_ZERO;
    endfunction

    logic [7:0] hundreds;
    logic [7:0] tens;
    logic [7:0] units;

    // ****************************************************************
    // Weighted sum as plain decimal text, most significant digit first
    // ****************************************************************
    always_comb begin
        hundreds = value / DEC_HUNDRED;
        tens     = (value % DEC_HUNDRED) / DEC_TEN;
        units    = value % DEC_TEN;
        text     = {to_ascii(hundreds), to_ascii(tens), to_ascii(units)};
        if (value >= DEC_HUNDRED) begin
            digits = 2'h3;
        end else if (value >= DEC_TEN) begin
            digits = 2'h2;
        end else begin
            digits = 2'h1;
        end
    end

endmodule

`default_nettype wire

// file: hw/isr_status_top.sv
// Instrument status reporting: event flags, masks, summary byte, service
// request
`timescale 1ns/1ps
`default_nettype none

module isr_status_top (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             serial_link,
    input  wire logic             cmd_valid,
    input  wire isr_pkg::isr_cmd_t cmd_code,
    input  wire logic [7:0]       cmd_param,
    input  wire logic             parse_error_evt,
    input  wire logic             run_failure_evt,
    input  wire logic             device_fault_evt,
    input  wire logic             query_fault_evt,
    input  wire logic             ops_pending,
    input  wire logic             error_summary_in,
    input  wire logic             completion_summary_in,
    input  wire logic             output_message_ready,
    output var  logic             resp_valid,
    output var  logic [7:0]       resp_value,
    output var  logic [23:0]      resp_text,
    output var  logic [1:0]       resp_digits,
    output var  logic [7:0]       status_summary_byte,
    output var  logic [7:0]       standard_event_flags,
    output var  logic             service_request,
    output var  logic             clear_pulse
);
    import isr_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  sem;
        logic [7:0]  srm;
        logic        service_request_flag;
        logic        master_summary;
        isr_opc_t    operation_complete_flag;
        logic        resp_valid;
        logic [7:0]  resp_value;
        logic [23:0] resp_text;
        logic [1:0]  resp_digits;
        logic [7:0]  ssb;
        logic [7:0]  sef_view;
        logic        cls;
    } isr_state_t;

    isr_state_t state_reg;
    isr_state_t state_next;

    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  flag_set;
    logic        flag_clear;
    logic [7:0]  visible_flags;
    logic [7:0]  dec_value;
    logic [23:0] dec_text;
    logic [1:0]  dec_digits;
    logic        take;
    logic        opc_fire;

    // Bits that the serial link cannot report are forced low on read.
    function automatic logic [7:0] link_view(input logic [7:0] f,
                                             input logic       serial);
        return serial ? (f & SEF_SERIAL_MASK) : f;
    endfunction

    function automatic logic [7:0] one_hot(input int pos);
        return 8'h01 << pos;
    endfunction

    assign take = cmd_valid;

    // ****************************************************************
    // Operation-complete sequencing
    // ****************************************************************
    // Completion is only reported after the command was received, never
    // on its own, so a pending wait is dropped by the clear command.
    always_comb begin
        opc_fire = 1'b0;
        case (state_reg.operation_complete_flag)
            ISR_OPC_IDLE: begin
                opc_fire = take && cmd_code == ISR_CMD_OP_DONE &&
                           !ops_pending;
            end
            ISR_OPC_WAIT: begin
                opc_fire = !ops_pending;
            end
            default: begin
                opc_fire = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Event flag inputs
    // ****************************************************************
    always_comb begin
        flag_set = ZERO_BYTE;
        flag_set[SEF_PARSE_ERROR]  = parse_error_evt;
        flag_set[SEF_RUN_FAILURE]  = run_failure_evt;
        flag_set[SEF_DEVICE_FAULT] = device_fault_evt;
        flag_set[SEF_QUERY_FAULT]  = query_fault_evt;
        flag_set[SEF_OPERATION_COMPLETE] = opc_fire;
        flag_clear = take && (cmd_code == ISR_CMD_EVT_QUERY ||
                              cmd_code == ISR_CMD_CLEAR);
    end

    isr_flag_latch #(
        .WIDTH     (REG_WIDTH),
        .RESET_VAL (SEF_RESET_VALUE),
        .USED_MASK (SEF_USED_MASK)
    ) u_flags (
        .clock     (clock),
        .reset     (reset),
        .set_vec   (flag_set),
        .clear_all (flag_clear),
        .flags_reg (flags_reg)
    );

    // Mirror of the latch's next value so summaries carry no lag.
    always_comb begin
        flags_next = (flag_clear ? ZERO_BYTE : flags_reg);
        flags_next = (flags_next | flag_set) & SEF_USED_MASK;
    end

    assign visible_flags = link_view(flags_reg, serial_link);

    isr_dec_text u_text (
        .value  (dec_value),
        .text   (dec_text),
        .digits (dec_digits)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next            = state_reg;
        state_next.resp_valid = 1'b0;
        state_next.cls        = 1'b0;
        dec_value             = ZERO_BYTE;

        if (state_reg.operation_complete_flag == ISR_OPC_WAIT && !ops_pending) begin
            state_next.operation_complete_flag = ISR_OPC_IDLE;
        end

        if (take) begin
            case (cmd_code)
                ISR_CMD_CLEAR: begin
                    state_next.cls = 1'b1;
                    state_next.operation_complete_flag = ISR_OPC_IDLE;
                end
                ISR_CMD_EVT_QUERY: begin
                    state_next.resp_valid = 1'b1;
                    dec_value = visible_flags;
                end
                ISR_CMD_EVM_WRITE: begin
                    state_next.sem = cmd_param;
                end
                ISR_CMD_EVM_QUERY: begin
                    state_next.resp_valid = 1'b1;
                    dec_value = state_reg.sem;
                end
                ISR_CMD_SRM_WRITE: begin
                    state_next.srm = cmd_param & SRM_USED_MASK;
                end
                ISR_CMD_SRM_QUERY: begin
                    state_next.resp_valid = 1'b1;
                    dec_value = state_reg.srm;
                end
                ISR_CMD_STB_QUERY: begin
                    state_next.resp_valid = 1'b1;
                    dec_value = state_reg.ssb;
                end
                ISR_CMD_SER_POLL: begin
                    state_next.resp_valid = 1'b1;
                    dec_value = state_reg.ssb;
                    dec_value[SSB_MASTER_SUMMARY] = state_reg.service_request_flag;
                end
                ISR_CMD_OP_DONE: begin
                    if (ops_pending) begin
                        state_next.operation_complete_flag = ISR_OPC_WAIT;
                    end
                end
                default: begin
                    state_next.operation_complete_flag = state_next.operation_complete_flag;
                end
            endcase
        end

        if (state_next.resp_valid) begin
            state_next.resp_value  = dec_value;
            state_next.resp_text   = dec_text;
            state_next.resp_digits = dec_digits;
        end

        // Summary byte is rebuilt every cycle from live conditions.
        state_next.ssb = ZERO_BYTE;
        state_next.ssb[SSB_EVENT_SUMMARY] =
            |(flags_next & state_next.sem);
        state_next.ssb[SSB_MESSAGE_READY] =
            output_message_ready && !serial_link;
        state_next.ssb[SSB_ERROR_SUMMARY] = error_summary_in;
        state_next.ssb[SSB_COMPLETION_SUMMARY] =
            completion_summary_in;
        state_next.master_summary = |(state_next.ssb & state_next.srm);
        state_next.ssb[SSB_MASTER_SUMMARY] =
            |(state_next.ssb & SSB_USED_MASK & state_next.srm);
        state_next.ssb = state_next.ssb & SSB_USED_MASK;

        // A fresh rise of the master summary raises a request unless the serial
        // link is up; the poll or the clear command withdraws it, but a new rise wins.
        if (take && (cmd_code == ISR_CMD_SER_POLL ||
                     cmd_code == ISR_CMD_CLEAR)) begin
            state_next.service_request_flag = 1'b0;
        end
        if (state_next.master_summary && !state_reg.master_summary) begin
            state_next.service_request_flag = 1'b1;
        end
        if (serial_link) begin
            state_next.service_request_flag = 1'b0;
        end

        state_next.sef_view = link_view(flags_next, serial_link);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg.sem         <= SEM_RESET_VALUE;
            state_reg.srm         <= SRM_RESET_VALUE;
            state_reg.service_request_flag         <= 1'b0;
            state_reg.master_summary         <= 1'b0;
            state_reg.operation_complete_flag         <= ISR_OPC_IDLE;
            state_reg.resp_valid  <= 1'b0;
            state_reg.resp_value  <= ZERO_BYTE;
            state_reg.resp_text   <= 24'h000000;
            state_reg.resp_digits <= 2'h0;
            state_reg.ssb         <= ZERO_BYTE;
            state_reg.sef_view    <= SEF_RESET_VALUE;
            state_reg.cls         <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign resp_valid           = state_reg.resp_valid;
    assign resp_value           = state_reg.resp_value;
    assign resp_text            = state_reg.resp_text;
    assign resp_digits          = state_reg.resp_digits;
    assign status_summary_byte  = state_reg.ssb;
    assign standard_event_flags = state_reg.sef_view;
    assign service_request      = state_reg.service_request_flag;
    assign clear_pulse          = state_reg.cls;

endmodule

`default_nettype wire

// file: sim/isr_status_sva.sv
// Concurrent checks on the ports of the status-reporting block
`timescale 1ns/1ps
`default_nettype none

module isr_status_sva (
    input wire logic              clock,
    input wire logic              reset,
    input wire logic              serial_link,
    input wire logic              cmd_valid,
    input wire isr_pkg::isr_cmd_t cmd_code,
    input wire logic [7:0]        cmd_param,
    input wire logic              parse_error_evt,
    input wire logic              run_failure_evt,
    input wire logic              device_fault_evt,
    input wire logic              query_fault_evt,
    input wire logic              ops_pending,
    input wire logic              error_summary_in,
    input wire logic              completion_summary_in,
    input wire logic              output_message_ready,
    input wire logic              resp_valid,
    input wire logic [7:0]        resp_value,
    input wire logic [23:0]       resp_text,
    input wire logic [1:0]        resp_digits,
    input wire logic [7:0]        status_summary_byte,
    input wire logic [7:0]        standard_event_flags,
    input wire logic              service_request,
    input wire logic              clear_pulse
);
    import isr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic evt_any;
    logic is_query;
    assign evt_any = parse_error_evt | run_failure_evt | device_fault_evt
                   | query_fault_evt;
    assign is_query = cmd_valid && cmd_code inside {ISR_CMD_EVT_QUERY,
        ISR_CMD_EVM_QUERY, ISR_CMD_SRM_QUERY, ISR_CMD_STB_QUERY,
        ISR_CMD_SER_POLL};

    // ****************************************************************
    // Multi-step behaviours
    // ****************************************************************
    sequence s_clear_cmd;
        cmd_valid && cmd_code == ISR_CMD_CLEAR && !evt_any;
    endsequence
    sequence s_cleared;
        clear_pulse && standard_event_flags == 8'h00
            && !status_summary_byte[5];
    endsequence
    sequence s_evt_query;
        cmd_valid && cmd_code == ISR_CMD_EVT_QUERY && !evt_any
            && !serial_link;
    endsequence
    sequence s_evt_answer;
        resp_valid && standard_event_flags == 8'h00
            && resp_value == $past(standard_event_flags);
    endsequence

    a_query_answer: assert property (is_query |=> resp_valid)
        else $error("query not answered next cycle");
    a_no_answer: assert property (!is_query |=> !resp_valid)
        else $error("answer without a query");
    a_unused_flags: assert property ((standard_event_flags & 8'h42) == 8'h00)
        else $error("unused flag bit set");
    a_unused_status: assert property ((status_summary_byte & 8'h83) == 8'h00)
        else $error("unused status bit set");
    a_parse_sets: assert property (parse_error_evt |=> standard_event_flags[5])
        else $error("parse error flag not set");
    a_fault_sets: assert property (run_failure_evt || device_fault_evt |=>
        (standard_event_flags[4:3] & $past({run_failure_evt, device_fault_evt}))
            == $past({run_failure_evt, device_fault_evt}))
        else $error("run or device fault flag not set");
    a_serial_masks: assert property (serial_link && $past(serial_link) |->
        !standard_event_flags[2] && !status_summary_byte[4] && !service_request)
        else $error("serial link masking broken");
    a_summary_source: assert property (status_summary_byte[5] && !serial_link
        && !$past(serial_link) |-> standard_event_flags != 8'h00)
        else $error("event summary without a flag");
    a_master_summary: assert property (status_summary_byte[6] |->
        status_summary_byte[5:2] != 4'h0)
        else $error("master summary without a source");
    a_status_follow: assert property (!$past(reset) && !serial_link
        && !$past(serial_link) |-> status_summary_byte[4:2] == $past(
        {output_message_ready, error_summary_in, completion_summary_in}))
        else $error("status bits 4..2 do not follow inputs");
    a_srq_on_rise: assert property ($rose(status_summary_byte[6])
        && !serial_link && !$past(serial_link) |-> service_request)
        else $error("service request not raised");
    a_event_query: assert property (s_evt_query |=> s_evt_answer)
        else $error("event query did not answer and clear");
    a_clear_cmd: assert property (s_clear_cmd |=> s_cleared)
        else $error("clear command did not clear");
    a_opc_done: assert property (cmd_valid && cmd_code == ISR_CMD_OP_DONE
        && !ops_pending |=> standard_event_flags[0])
        else $error("operation complete flag not set");
endmodule

`default_nettype wire

// file: sim/isr_host_model.sv
// Host controller model: issues common commands and collects answers
`timescale 1ns/1ps
`default_nettype none

module isr_host_model (
    input  wire logic              clock,
    output var  logic              cmd_valid,
    output var  isr_pkg::isr_cmd_t cmd_code,
    output var  logic [7:0]        cmd_param,
    input  wire logic              resp_valid,
    input  wire logic [7:0]        resp_value,
    input  wire logic [23:0]       resp_text,
    input  wire logic [1:0]        resp_digits
);
    import isr_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd_code = ISR_CMD_NONE;
        cmd_param = 8'h00;
    end

    // Held one cycle up to the taking edge; the idle parameter is
    // inverted so a design reading it outside a command sees garbage
    task automatic send(input isr_cmd_t code, input logic [7:0] param);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_param <= param; // Weighted sum as binary
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code <= ISR_CMD_NONE;
        cmd_param <= ~param;
    endtask

    task automatic ask(input isr_cmd_t code, output logic ok,
                       output logic [7:0] v, output logic [23:0] t,
                       output logic [1:0] d);
        send(code, 8'h00);
        #1;
        ok = resp_valid;
        v = resp_value;
        t = resp_text;
        d = resp_digits;
    endtask
endmodule

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the status-reporting block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import isr_pkg::*;
    logic        clock, reset, serial_link, cmd_valid, ops_pending;
    logic        parse_error_evt, run_failure_evt, device_fault_evt;
    logic        query_fault_evt, error_summary_in, completion_summary_in;
    logic        output_message_ready, resp_valid, service_request;
    logic        clear_pulse;
    isr_cmd_t    cmd_code;
    logic [7:0]  cmd_param, resp_value, status_summary_byte;
    logic [7:0]  standard_event_flags;
    logic [23:0] resp_text;
    logic [1:0]  resp_digits;
    int          fails, checks_done, cycles;

    isr_status_top u_dut (.clock, .reset, .serial_link, .cmd_valid,
        .cmd_code, .cmd_param, .parse_error_evt, .run_failure_evt,
        .device_fault_evt, .query_fault_evt, .ops_pending,
        .error_summary_in, .completion_summary_in, .output_message_ready,
        .resp_valid, .resp_value, .resp_text, .resp_digits,
        .status_summary_byte, .standard_event_flags, .service_request,
        .clear_pulse);
    isr_host_model u_host (.clock, .cmd_valid, .cmd_code, .cmd_param,
        .resp_valid, .resp_value, .resp_text, .resp_digits);

    always #4 clock = ~clock;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic report_and_stop;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [23:0] e,
                         input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // Query with the expected decimal rendering worked out here
    task automatic q(input isr_cmd_t c, input logic [7:0] e);
        logic ok;
        logic [7:0] v;
        logic [23:0] t;
        logic [1:0] d;
        u_host.ask(c, ok, v, t, d);
        check("resp_valid", 24'h1, {23'h0, ok});
        check("resp_value", {16'h0, e}, {16'h0, v});
        check("resp_text", {8'h30 + e / 8'd100,
              8'h30 + (e / 8'd10) % 8'd10, 8'h30 + e % 8'd10}, t);
        check("resp_digits", (e > 99) ? 24'h3 : (e > 9) ? 24'h2 : 24'h1,
              {22'h0, d});
    endtask

    // Event pulse vector {parse, run, device, query}
    task automatic evt(input logic [3:0] v);
        @(posedge clock);
        {parse_error_evt, run_failure_evt, device_fault_evt,
         query_fault_evt} <= v;
        @(posedge clock);
        {parse_error_evt, run_failure_evt, device_fault_evt,
         query_fault_evt} <= 4'h0;
        #1;
    endtask

    task automatic ext(input logic [2:0] v);
        @(posedge clock);
        {output_message_ready, error_summary_in,
         completion_summary_in} <= v;
        @(posedge clock);
        #1;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {serial_link, ops_pending, parse_error_evt, run_failure_evt} = '0;
        {device_fault_evt, query_fault_evt, error_summary_in} = '0;
        {completion_summary_in, output_message_ready} = '0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        check("flags", 24'h80, {16'h0, standard_event_flags});
        check("status", 24'h0, {16'h0, status_summary_byte});
        q(ISR_CMD_EVM_QUERY, 8'h00);
        q(ISR_CMD_SRM_QUERY, 8'h00);
        q(ISR_CMD_EVT_QUERY, 8'h80);
        q(ISR_CMD_EVT_QUERY, 8'h00);
        evt(4'hf);
        check("flags", 24'h3c, {16'h0, standard_event_flags});
        q(ISR_CMD_EVT_QUERY, 8'h3c);
        u_host.send(ISR_CMD_EVM_WRITE, 8'h30);
        q(ISR_CMD_EVM_QUERY, 8'h30);
        evt(4'h4);
        check("status", 24'h20, {16'h0, status_summary_byte});
        u_host.send(ISR_CMD_SRM_WRITE, 8'hff);
        q(ISR_CMD_SRM_QUERY, 8'h3c);
        check("status", 24'h60, {16'h0, status_summary_byte});
        check("srq", 24'h1, {23'h0, service_request});
        q(ISR_CMD_STB_QUERY, 8'h60);
        q(ISR_CMD_SER_POLL, 8'h60);
        check("srq", 24'h0, {23'h0, service_request});
        q(ISR_CMD_SER_POLL, 8'h20);
        ext(3'h7);
        check("status", 24'h7c, {16'h0, status_summary_byte});
        serial_link <= 1'b1;
        evt(4'h1);
        check("flag2", 24'h0, {23'h0, standard_event_flags[2]});
        check("status4", 24'h0, {23'h0, status_summary_byte[4]});
        check("srq", 24'h0, {23'h0, service_request});
        ext(3'h0);
        serial_link <= 1'b0;
        @(posedge clock);
        ops_pending <= 1'b1;
        u_host.send(ISR_CMD_OP_DONE, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        check("opc", 24'h0, {23'h0, standard_event_flags[0]});
        @(posedge clock);
        ops_pending <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("opc", 24'h1, {23'h0, standard_event_flags[0]});
        u_host.send(ISR_CMD_CLEAR, 8'h00);
        #1;
        check("clear_pulse", 24'h1, {23'h0, clear_pulse});
        check("flags", 24'h0, {16'h0, standard_event_flags});
        check("status", 24'h0, {16'h0, status_summary_byte});
        u_host.send(ISR_CMD_EVM_WRITE, 8'h00);
        q(ISR_CMD_EVM_QUERY, 8'h00);
        report_and_stop();
    end
endmodule

bind isr_status_top isr_status_sva u_sva (.clock, .reset, .serial_link,
    .cmd_valid, .cmd_code, .cmd_param, .parse_error_evt, .run_failure_evt,
    .device_fault_evt, .query_fault_evt, .ops_pending, .error_summary_in,
    .completion_summary_in, .output_message_ready, .resp_valid,
    .resp_value, .resp_text, .resp_digits, .status_summary_byte,
    .standard_event_flags, .service_request, .clear_pulse);

`default_nettype wire
